/* inc/memory_sync_params.svh */
`ifndef MEMORY_SYNC_PARAMS_SVH
`define MEMORY_SYNC_PARAMS_SVH

// Effective address width
`define EA_W 32
// Reservation block is 32 bytes: address bits below this one are ignored
`define RESV_BLOCK_LSB 5
// Width of the reserved block number
`define RESV_BLOCK_W 27
// Word alignment: low two address bits must read as this value
`define WORD_ALIGN_BITS 2
`define WORD_ALIGN_OK 2'h0

`endif

/* inc/memory_sync_pkg.sv */
`include "memory_sync_params.svh"

package memory_sync_pkg;

    // Instruction classes handed over by the sequencer
    typedef enum logic [2:0] {
        OP_OTHER     = 3'b000,
        OP_EXEC_SYNC = 3'b001,
        OP_IO_ORDER  = 3'b010,
        OP_FETCH_SYNC = 3'b011,
        OP_LOAD_RESV = 3'b100,
        OP_STORE_COND = 3'b101,
        OP_SYS_CALL  = 3'b110
    } op_kind_t;

    // Barrier and bus-cycle sequencer states
    typedef enum logic [2:0] {
        ST_IDLE       = 3'b000,
        ST_SER_WAIT   = 3'b001,
        ST_BCAST      = 3'b010,
        ST_IO_WAIT    = 3'b011,
        ST_FETCH_WAIT = 3'b100,
        ST_LSB_WAIT   = 3'b101
    } sync_state_t;

    // One cycle on the load/store bus toward the external bus unit
    typedef struct packed {
        logic valid;
        logic write;
        logic reserve;
        logic external;
        logic [`EA_W-1:0] addr;
    } lsb_cycle_t;

    // Result of a finished atomic instruction
    typedef struct packed {
        logic done;
        logic match_flag;
        logic align_exc;
        logic ext_block;
    } atomic_result_t;

endpackage

/* logic/memory_sync_reservation.sv */
// What this block does
// (RL1) Execution barrier stalls later instructions until drained, performed and broadcast.
// (RL2) After I/O barrier, no load/store issues until earlier ones finish.
// (RL3) Fetch barrier halts fetch until all issued and prefetched instructions complete.
// (RL4) Reservations cover a whole 32-byte block.
// (RL5) Conditional store with reservation stores and sets the success flag.
// (RL6) Conditional store without reservation leaves memory alone, flag zero.
// (RL7) Load-and-reserve and conditional store need an aligned effective address.
// (RL8) One reservation only; each new aligned load-and-reserve replaces its address.
// (RL9) Conditional store success ignores address match, only reservation existence.
// (RL10) Clear on conditional store, system call, exceptions, or foreign block write to an external reservation.
// (RL11) Each aligned load-and-reserve issues a bus cycle with the reserve attribute.
// (RL12) Reserving cycle to external memory records an external reservation.
// (RL13) Broken external reservation seen by own snoop or external snoop indication.
// (RL14) External conditional store with lost reservation is blocked and reported.
// (RL15) Misaligned atomic address raises the alignment exception.
// (RL16) Success reported in match flag of condition field zero.
// (RL17) No reservation after reset.
`timescale 1ns/1ps
`default_nettype none
`include "memory_sync_params.svh"

module memory_sync_reservation
    import memory_sync_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Instruction hand-over from the sequencer
    input wire logic op_valid,
    input wire op_kind_t op_kind,
    input wire logic [`EA_W-1:0] effective_address,
    input wire logic op_external,
    output logic op_ready_r,
    // Pipeline status
    input wire logic pipe_empty,
    input wire logic mem_performed,
    input wire logic ldst_idle,
    input wire logic core_idle,
    // Exception events
    input wire logic exc_instr,
    input wire logic async_exc,
    // Stall outputs
    output logic exec_stall_r,
    output logic ldst_stall_r,
    output logic fetch_halt_r,
    // Barrier broadcast on the external bus
    output logic bcast_req_r,
    input wire logic bcast_ack,
    // Load/store bus
    output lsb_cycle_t lsb_r,
    input wire logic lsb_ack,
    // Snoop of the external bus, same clock
    input wire logic snoop_write,
    input wire logic [`EA_W-1:0] snoop_addr,
    // Break indication pin from external snoop logic
    input wire logic resv_break_pin,
    // Results
    output atomic_result_t result_r,
    output logic resv_valid_r
);

    // Block number of an address
    function automatic logic [`RESV_BLOCK_W-1:0] block_of(input logic [`EA_W-1:0] a);
        block_of = a[`EA_W-1:`RESV_BLOCK_LSB];
    endfunction

    sync_state_t state_r, state_nxt;
    logic [`RESV_BLOCK_W-1:0] resv_block_r;
    logic resv_ext_r;
    logic store_r;
    logic brk_s1_r, brk_s2_r, brk_s3_r, brk_q_r;

    // Break pin synchroniser, change taken when second and third agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            brk_s1_r <= 1'b0;
            brk_s2_r <= 1'b0;
            brk_s3_r <= 1'b0;
            brk_q_r <= 1'b0;
        end else begin
            brk_s1_r <= resv_break_pin;
            brk_s2_r <= brk_s1_r;
            brk_s3_r <= brk_s2_r;
            if (brk_s2_r == brk_s3_r) begin
                brk_q_r <= brk_s3_r;
            end
        end
    end

    // Decode of the offered instruction
    wire accept = op_valid && op_ready_r;
    wire is_atomic = (op_kind == OP_LOAD_RESV) || (op_kind == OP_STORE_COND);
    wire misaligned = effective_address[`WORD_ALIGN_BITS-1:0] != `WORD_ALIGN_OK; // RL7
    wire align_fault = accept && is_atomic && misaligned; // RL15
    wire lr_go = accept && op_kind == OP_LOAD_RESV && !misaligned;
    wire sc_go = accept && op_kind == OP_STORE_COND && !misaligned;
    wire sc_ok = sc_go && resv_valid_r; // RL9
    wire sc_fail = sc_go && !resv_valid_r; // RL6

    // Foreign access to the reserved block, own snoop or external indication
    wire snoop_hit = snoop_write && block_of(snoop_addr) == resv_block_r; // RL4
    wire break_now = resv_ext_r && (snoop_hit || brk_q_r); // RL13

    // External conditional store that lost its reservation mid-flight
    wire in_lsb = state_r == ST_LSB_WAIT;
    wire sc_lost = in_lsb && store_r && lsb_r.external && break_now; // RL14
    wire lsb_end = in_lsb && (lsb_ack || sc_lost);
    wire resv_set = in_lsb && !store_r && lsb_ack; // RL8

    // Reservation clear events
    wire sys_call = accept && op_kind == OP_SYS_CALL;
    wire resv_clr = (accept && op_kind == OP_STORE_COND) || sys_call || align_fault ||
                    exc_instr || async_exc || break_now; // RL10
    wire resv_valid_nxt = resv_set || (resv_valid_r && !resv_clr);

    // An external conditional store keeps watching its block until its bus cycle ends
    wire watch_keep = sc_ok || (in_lsb && store_r && !lsb_end); // RL14

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    case (op_kind)
                        OP_EXEC_SYNC: state_nxt = ST_SER_WAIT;
                        OP_IO_ORDER: state_nxt = ST_IO_WAIT;
                        OP_FETCH_SYNC: state_nxt = ST_FETCH_WAIT;
                        default: state_nxt = (lr_go || sc_ok) ? ST_LSB_WAIT : ST_IDLE;
                    endcase
                end
            end
            ST_SER_WAIT: begin
                if (pipe_empty && mem_performed) begin
                    state_nxt = ST_BCAST; // RL1
                end
            end
            ST_BCAST: begin
                if (bcast_ack) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IO_WAIT: begin
                if (ldst_idle) begin
                    state_nxt = ST_IDLE; // RL2
                end
            end
            ST_FETCH_WAIT: begin
                if (core_idle) begin
                    state_nxt = ST_IDLE; // RL3
                end
            end
            ST_LSB_WAIT: begin
                if (lsb_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State and barrier outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            op_ready_r <= 1'b0;
            exec_stall_r <= 1'b0;
            ldst_stall_r <= 1'b0;
            fetch_halt_r <= 1'b0;
            bcast_req_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_ready_r <= state_nxt == ST_IDLE;
            exec_stall_r <= state_nxt == ST_SER_WAIT || state_nxt == ST_BCAST; // RL1
            ldst_stall_r <= state_nxt == ST_IO_WAIT; // RL2
            fetch_halt_r <= state_nxt == ST_FETCH_WAIT; // RL3
            bcast_req_r <= state_nxt == ST_BCAST; // RL1
        end
    end

    // Reservation register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resv_valid_r <= 1'b0; // RL17
            resv_block_r <= '0;
            resv_ext_r <= 1'b0;
        end else begin
            resv_valid_r <= resv_valid_nxt;
            if (resv_set) begin
                resv_block_r <= block_of(lsb_r.addr); // RL8
                resv_ext_r <= lsb_r.external; // RL12
            end else if (!resv_valid_nxt && !watch_keep) begin
                resv_ext_r <= 1'b0;
            end
        end
    end

    // Load/store bus cycle, held until acknowledged or blocked
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lsb_r <= '0;
            store_r <= 1'b0;
        end else if (lr_go || sc_ok) begin
            lsb_r.valid <= 1'b1; // RL11 RL5
            lsb_r.write <= sc_ok;
            lsb_r.reserve <= lr_go; // RL11
            lsb_r.external <= op_external;
            lsb_r.addr <= effective_address;
            store_r <= sc_ok;
        end else if (lsb_end) begin
            lsb_r.valid <= 1'b0; // RL14
        end
    end

    // Atomic result pulses
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_r <= '0;
        end else begin
            result_r.done <= sc_fail || (lsb_end && store_r) || align_fault;
            result_r.match_flag <= lsb_end && store_r && !sc_lost; // RL16 RL5
            result_r.align_exc <= align_fault; // RL15
            result_r.ext_block <= sc_lost; // RL14
        end
    end

    // Checks
    property p_exec_hold;
        @(posedge core_clk) disable iff (rst) bcast_req_r |-> exec_stall_r;
    endproperty
    a_exec_hold: assert property (p_exec_hold) else $error("Broadcast without stall"); // RL1

    property p_io_hold;
        @(posedge core_clk) disable iff (rst) ldst_stall_r && !ldst_idle |=> ldst_stall_r;
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("Load/store stall released early"); // RL2

    property p_fetch_hold;
        @(posedge core_clk) disable iff (rst) fetch_halt_r && !core_idle |=> fetch_halt_r;
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("Fetch resumed early"); // RL3

    property p_sc_store;
        @(posedge core_clk) disable iff (rst) sc_go && resv_valid_r |=> lsb_r.valid && lsb_r.write;
    endproperty
    a_sc_store: assert property (p_sc_store) else $error("Reserved store not issued"); // RL5

    property p_sc_fail;
        @(posedge core_clk) disable iff (rst)
            sc_go && !resv_valid_r |=> result_r.done && !result_r.match_flag && !lsb_r.valid;
    endproperty
    a_sc_fail: assert property (p_sc_fail) else $error("Unreserved store misreported"); // RL6

    property p_align;
        @(posedge core_clk) disable iff (rst) accept && is_atomic && misaligned |=> result_r.align_exc;
    endproperty
    a_align: assert property (p_align) else $error("Alignment fault missed"); // RL15

    property p_replace;
        @(posedge core_clk) disable iff (rst) resv_set |=> resv_valid_r && resv_block_r == block_of($past(lsb_r.addr));
    endproperty
    a_replace: assert property (p_replace) else $error("Reservation not replaced"); // RL8

    property p_clear;
        @(posedge core_clk) disable iff (rst) (sys_call || async_exc || exc_instr) && !resv_set |=> !resv_valid_r;
    endproperty
    a_clear: assert property (p_clear) else $error("Reservation survived clear"); // RL10

    property p_reserve_attr;
        @(posedge core_clk) disable iff (rst) lr_go |=> lsb_r.valid && lsb_r.reserve && !lsb_r.write;
    endproperty
    a_reserve_attr: assert property (p_reserve_attr) else $error("Reserve cycle missing"); // RL11

    property p_lost;
        @(posedge core_clk) disable iff (rst) sc_lost |=> result_r.ext_block && !lsb_r.valid;
    endproperty
    a_lost: assert property (p_lost) else $error("Lost store not blocked"); // RL14

    property p_reset;
        @(posedge core_clk) $fell(rst) |-> !resv_valid_r;
    endproperty
    a_reset: assert property (p_reset) else $error("Reservation after reset"); // RL17

endmodule
`default_nettype wire

/* test/bus_unit_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_unit_model
    import memory_sync_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Requests from the block, and the acknowledge wait set by the test
    input wire lsb_cycle_t lsb_r,
    input wire logic bcast_req_r,
    input wire logic [3:0] wait_cycles,
    // Answers
    output logic lsb_ack,
    output logic bcast_ack
);
    logic [3:0] cnt_r;
    // Accept one cycle after the chosen wait, and acknowledge each broadcast
    always @(negedge core_clk) begin
        lsb_ack <= 1'b0;
        bcast_ack <= bcast_req_r && !bcast_ack;
        if (!lsb_r.valid) begin
            cnt_r <= 4'h0;
        end else if (!lsb_ack && cnt_r >= wait_cycles) begin
            lsb_ack <= 1'b1;
            cnt_r <= 4'h0;
        end else if (!lsb_ack) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* test/tb_memory_sync_reservation.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_memory_sync_reservation
    import memory_sync_pkg::*;
;
    logic core_clk, rst, op_valid, op_external, op_ready_r, pipe_empty, mem_performed, ldst_idle, core_idle;
    logic exc_instr, async_exc, exec_stall_r, ldst_stall_r, fetch_halt_r, bcast_req_r, bcast_ack, lsb_ack;
    logic snoop_write, resv_break_pin, resv_valid_r, bcast_seen;
    logic [31:0] effective_address, snoop_addr;
    logic [3:0] wait_cycles;
    op_kind_t op_kind;
    lsb_cycle_t lsb_r, last_lsb;
    atomic_result_t result_r, r;
    int n_fail = 0, total_checks = 0, n_lsb = 0;

    memory_sync_reservation DUT (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_kind(op_kind),
        .effective_address(effective_address), .op_external(op_external), .op_ready_r(op_ready_r),
        .pipe_empty(pipe_empty), .mem_performed(mem_performed), .ldst_idle(ldst_idle), .core_idle(core_idle),
        .exc_instr(exc_instr), .async_exc(async_exc), .exec_stall_r(exec_stall_r), .ldst_stall_r(ldst_stall_r),
        .fetch_halt_r(fetch_halt_r), .bcast_req_r(bcast_req_r), .bcast_ack(bcast_ack), .lsb_r(lsb_r),
        .lsb_ack(lsb_ack), .snoop_write(snoop_write), .snoop_addr(snoop_addr),
        .resv_break_pin(resv_break_pin), .result_r(result_r), .resv_valid_r(resv_valid_r));
    bus_unit_model partner (.core_clk(core_clk), .lsb_r(lsb_r), .bcast_req_r(bcast_req_r),
        .wait_cycles(wait_cycles), .lsb_ack(lsb_ack), .bcast_ack(bcast_ack));

    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #(25 * 5000);
        n_fail++;
        give_verdict;
    end
    // Record bus cycles and broadcasts as the block shows them
    always @(posedge core_clk) begin
        if (lsb_r.valid === 1'b1) begin
            last_lsb = lsb_r;
            n_lsb++;
        end
        if (bcast_req_r === 1'b1) bcast_seen = 1'b1;
    end

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic settle;
        for (int i = 0; i < 50 && op_ready_r !== 1'b1; i++) @(negedge core_clk);
        if (op_ready_r !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t ready timeout", $time);
        end
    endtask
    task automatic issue(input op_kind_t k, input logic [31:0] a, input logic ext);
        settle;
        op_valid = 1'b1;
        op_kind = k;
        effective_address = a;
        op_external = ext;
        @(negedge core_clk);
        op_valid = 1'b0;
    endtask
    task automatic wait_done;
        r = result_r;
        for (int i = 0; i < 50 && r.done !== 1'b1; i++) begin
            @(negedge core_clk);
            r = result_r;
        end
        if (r.done !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t result timeout", $time);
        end
    endtask
    task automatic snoop(input logic [31:0] a);
        snoop_write = 1'b1;
        snoop_addr = a;
        @(negedge core_clk);
        snoop_write = 1'b0;
        tick(2);
    endtask
    function automatic logic stall_of(input int i);
        return (i == 0) ? exec_stall_r : (i == 1) ? ldst_stall_r : fetch_halt_r;
    endfunction

    task automatic t_fresh_store;
        int n0;
        n0 = n_lsb;
        check(resv_valid_r === 1'b0, "reservation after reset");
        issue(OP_STORE_COND, 32'h0000_0040, 1'b0);
        wait_done;
        check(r.match_flag === 1'b0 && n_lsb === n0, "store without reservation");
        $display("test fresh_store done");
    endtask
    task automatic t_reserve_store;
        issue(OP_LOAD_RESV, 32'h1000_0044, 1'b1);
        settle;
        check(last_lsb.reserve === 1'b1 && last_lsb.write === 1'b0, "reserve attribute");
        check(last_lsb.addr === 32'h1000_0044 && resv_valid_r === 1'b1, "reservation set");
        issue(OP_STORE_COND, 32'h2000_0100, 1'b0);
        wait_done;
        check(r.match_flag === 1'b1 && last_lsb.write === 1'b1, "store with reservation");
        check(resv_valid_r === 1'b0, "reservation kept after store");
        $display("test reserve_store done");
    endtask
    task automatic t_replace;
        issue(OP_LOAD_RESV, 32'h0000_0040, 1'b1);
        issue(OP_LOAD_RESV, 32'h0000_0080, 1'b1);
        settle;
        snoop(32'h0000_005C);
        check(resv_valid_r === 1'b1, "old block still reserved");
        snoop(32'h0000_00A0);
        check(resv_valid_r === 1'b1, "neighbour block cleared");
        snoop(32'h0000_009C);
        check(resv_valid_r === 1'b0, "snoop hit missed");
        $display("test replace done");
    endtask
    task automatic t_misalign;
        int n0;
        for (int i = 0; i < 2; i++) begin
            issue(OP_LOAD_RESV, 32'h0000_0100, 1'b0);
            settle;
            n0 = n_lsb;
            issue(i ? OP_STORE_COND : OP_LOAD_RESV, 32'h0000_0102 - i, 1'b0);
            wait_done;
            check(r.align_exc === 1'b1 && r.match_flag === 1'b0 && n_lsb === n0, "misaligned op");
            tick(1);
            check(resv_valid_r === 1'b0, "reservation after alignment fault");
        end
        $display("test misalign done");
    endtask
    task automatic t_clears;
        for (int i = 0; i < 4; i++) begin
            issue(OP_LOAD_RESV, 32'h0000_0300, 1'b1);
            settle;
            exc_instr = (i == 1);
            async_exc = (i == 2);
            resv_break_pin = (i == 3);
            if (i == 0) issue(OP_SYS_CALL, 32'h0, 1'b0);
            else tick(1);
            exc_instr = 1'b0;
            async_exc = 1'b0;
            tick(6);
            resv_break_pin = 1'b0;
            check(resv_valid_r === 1'b0, "reservation survived clear event");
        end
        // Let the break synchroniser return to idle before the next reservation
        tick(4);
        $display("test clears done");
    endtask
    task automatic t_lost;
        issue(OP_LOAD_RESV, 32'h0000_0200, 1'b1);
        settle;
        wait_cycles = 4'h8;
        issue(OP_STORE_COND, 32'h0000_0204, 1'b1);
        tick(1);
        snoop_write = 1'b1;
        snoop_addr = 32'h0000_021C;
        @(negedge core_clk);
        snoop_write = 1'b0;
        wait_done;
        check(r.ext_block === 1'b1 && r.match_flag === 1'b0, "lost store not blocked");
        wait_cycles = 4'h1;
        $display("test lost done");
    endtask
    task automatic t_reset;
        issue(OP_LOAD_RESV, 32'h0000_0400, 1'b1);
        settle;
        check(resv_valid_r === 1'b1, "reservation before reset");
        rst = 1'b1;
        tick(3);
        check(op_ready_r === 1'b0 && lsb_r.valid === 1'b0, "outputs during reset");
        rst = 1'b0;
        tick(1);
        check(resv_valid_r === 1'b0 && op_ready_r === 1'b1, "reservation after mid-run reset");
        issue(OP_STORE_COND, 32'h0000_0400, 1'b1);
        wait_done;
        check(r.done === 1'b1 && r.match_flag === 1'b0, "store after mid-run reset");
        $display("test reset done");
    endtask
    task automatic t_barriers;
        op_kind_t kinds[3];
        kinds = '{OP_EXEC_SYNC, OP_IO_ORDER, OP_FETCH_SYNC};
        for (int i = 0; i < 3; i++) begin
            {pipe_empty, mem_performed} = {2{i != 0}};
            ldst_idle = (i != 1);
            core_idle = (i != 2);
            bcast_seen = 1'b0;
            issue(kinds[i], 32'h0, 1'b0);
            tick(4);
            check(stall_of(i) === 1'b1 && op_ready_r === 1'b0 && bcast_seen === 1'b0, "early release");
            {pipe_empty, mem_performed, ldst_idle, core_idle} = 4'hF;
            settle;
            check(stall_of(i) === 1'b0 && (i != 0 || bcast_seen === 1'b1), "barrier stuck");
        end
        $display("test barriers done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst, op_valid, op_external, exc_instr, async_exc, snoop_write, resv_break_pin} = 7'h40;
        {pipe_empty, mem_performed, ldst_idle, core_idle} = 4'hF;
        op_kind = OP_OTHER;
        effective_address = 32'h0;
        snoop_addr = 32'h0;
        wait_cycles = 4'h1;
        bcast_seen = 1'b0;
        tick(20);
        rst = 1'b0;
        tick(1);
        t_fresh_store;
        t_reserve_store;
        t_replace;
        t_misalign;
        t_clears;
        t_lost;
        t_reset;
        t_barriers;
        give_verdict;
    end
endmodule
`default_nettype wire
